// ### src/fbess_pkg.sv
package fbess_pkg;

  // clock rate and timing figures
  localparam int CLK_MHZ = 250;
  localparam int SE_WINDOW_US = 35;
  localparam int SUSP_LAT_US = 20;
  localparam int PROG_US = 10;
  localparam int PREPROG_US = 100;
  localparam int ERASE_US = 400;
  localparam int SE_WINDOW_CYC = SE_WINDOW_US * CLK_MHZ;
  localparam int SUSP_LAT_CYC = SUSP_LAT_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int PREPROG_CYC = PREPROG_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
  localparam int CNT_W = 24;

  // flash bus geometry
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int NBANK = 4;
  localparam int BANK_W = 2;
  localparam int BANK_LO = 19;
  localparam int SECT_W = 6;
  localparam int SECT_LO = 13;
  localparam int NSECT = 64;
  localparam int UNLK_W = 12;
  localparam int CODE_W = 8;

  // command codes, low data byte only
  localparam logic [CODE_W-1:0] CMD_UNLK1 = 8'hAA;
  localparam logic [CODE_W-1:0] CMD_UNLK2 = 8'h55;
  localparam logic [CODE_W-1:0] CMD_BYPASS = 8'h20;
  localparam logic [CODE_W-1:0] CMD_PROG = 8'hA0;
  localparam logic [CODE_W-1:0] CMD_SETUP = 8'h80;
  localparam logic [CODE_W-1:0] CMD_CHIP = 8'h10;
  localparam logic [CODE_W-1:0] CMD_SECTOR = 8'h30;
  localparam logic [CODE_W-1:0] CMD_RESUME = 8'h30;
  localparam logic [CODE_W-1:0] CMD_SUSPEND = 8'hB0;
  localparam logic [CODE_W-1:0] CMD_AUTOSEL = 8'h90;
  localparam logic [CODE_W-1:0] CMD_BYP_EXIT = 8'h00;
  localparam logic [CODE_W-1:0] CMD_RESET = 8'hF0;
  localparam logic [UNLK_W-1:0] ADDR_UNLK1 = 12'h555;
  localparam logic [UNLK_W-1:0] ADDR_UNLK2 = 12'h2AA;

  // status word bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int WINDOW_BIT = 3;
  localparam int ETOGGLE_BIT = 2;

  // register map
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h00;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_LOCK_BIT = 0;
  localparam int STAT_STRIDE = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_READ = 4'b0000,
    ST_UNLK1 = 4'b0001,
    ST_UNLK2 = 4'b0010,
    ST_SETUP = 4'b0011,
    ST_SU_UNLK1 = 4'b0100,
    ST_SU_UNLK2 = 4'b0101,
    ST_PROG_ADDR = 4'b0110,
    ST_PROG_BUSY = 4'b0111,
    ST_BYP_80 = 4'b1000,
    ST_BYP_RST = 4'b1001,
    ST_CHIP_BUSY = 4'b1010,
    ST_SE_WINDOW = 4'b1011,
    ST_SE_BUSY = 4'b1100,
    ST_AUTOSEL = 4'b1101
  } fbess_state_e;

endpackage

// ### src/fbess_top.sv
// Function
// R1: AA/55 unlock then 20h enters bypass
// R2: bypass program is A0h then address/data
// R3: bypass chip erase takes two writes
// R4: bypass sector erase takes two writes
// R5: bypass mode accepts only four sequences
// R6: 90h at bank then 00h exits bypass
// R7: elevated accel input forces bypass mode
// R8: six-write chip erase, writes ignored meanwhile
// R9: erase preprograms then erases, self-timed
// R10: erase end returns read; status bits reported
// R11: hardware reset aborts erase immediately
// R12: six-write sector erase ends sector/30h
// R13: 35 us window accepts more sectors
// R14: window restarts at each write strobe rise
// R15: foreign write in window aborts to read
// R16: window bit shows window expiry
// R17: other banks read array data
// R18: running sector erase accepts only suspend
// R19: B0h suspend only during sector erase
// R20: suspend within latency, window suspends at once
// R21: suspended sectors read status, others array
// R22: autoselect allowed; program returns to suspend
// R23: resume restarts erase, extra resumes ignored
// R24: bypass sector pair is 80h then 30h
// R25: upper data byte ignored in commands
// R26: per-bank state selected by bank address
`timescale 1ns/1ns
module fbess_top
  import fbess_pkg::*;
#(
  parameter int SE_WINDOW_CYCLES = SE_WINDOW_CYC,
  parameter int SUSP_LAT_CYCLES = SUSP_LAT_CYC,
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int PREPROG_CYCLES = PREPROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic accel_program_input,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_data_in,
  output logic [DATA_W-1:0] flash_data_out,
  output logic flash_data_oe,
  output logic [ADDR_W-1:0] array_raddr,
  input wire logic [DATA_W-1:0] array_rdata,
  output logic array_wr_en,
  output logic [ADDR_W-1:0] array_wr_addr,
  output logic [DATA_W-1:0] array_wr_data,
  output logic [NBANK-1:0] bank_busy
);

  localparam int SYN_W = 3 + ADDR_W + DATA_W;

  function automatic logic is_cmd(input logic [CODE_W-1:0] code, input logic [UNLK_W-1:0] low,
                                  input logic [CODE_W-1:0] want, input logic [UNLK_W-1:0] at);
    is_cmd = (code == want) && (low == at);
  endfunction

  // pin synchroniser: three stages, a change counts once stages two and three agree
  logic [SYN_W-1:0] sy1_r, sy2_r, sy3_r, stab_r;
  wire [SYN_W-1:0] pins = {flash_we_n, flash_oe_n, accel_program_input, flash_addr, flash_data_in};

  wire we_s = stab_r[SYN_W-1];
  wire oe_s = stab_r[SYN_W-2];
  wire acc_s = stab_r[SYN_W-3];
  wire [ADDR_W-1:0] addr_s = stab_r[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] data_s = stab_r[DATA_W-1:0];

  logic we_prev_r, oe_prev_r, tog_r, ctrl_lock_r;

  // writes latch on the rising edge of the write strobe
  wire wr_ev = we_s && !we_prev_r; // R14
  wire rd_ev = !oe_s && oe_prev_r;
  wire cmd_ev = wr_ev && !ctrl_lock_r;
  wire [CODE_W-1:0] wr_code = data_s[CODE_W-1:0]; // R25
  wire [UNLK_W-1:0] wr_low = addr_s[UNLK_W-1:0];
  wire [BANK_W-1:0] wr_bank = addr_s[BANK_LO +: BANK_W];
  wire [SECT_W-1:0] wr_sect = addr_s[SECT_LO +: SECT_W];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {sy1_r, sy2_r, sy3_r, stab_r} <= '1;
      {we_prev_r, oe_prev_r} <= 2'b11;
      tog_r <= 1'b0;
    end else begin
      sy1_r <= pins;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      if (sy2_r == sy3_r) begin
        stab_r <= sy3_r;
      end
      we_prev_r <= we_s;
      oe_prev_r <= oe_s;
      tog_r <= tog_r ^ rd_ev;
    end
  end

  logic [NBANK-1:0] prog_go, busy_w, erase_w, susp_w, byp_w;
  logic [NBANK-1:0][3:0] st_w;
  logic [NBANK-1:0][NSECT-1:0] sel_w;
  logic [31:0] status_reg;

  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    fbess_state_e st_r, st_nxt;
    logic byp_r, byp_nxt, susp_r, susp_nxt, pre_r, pre_nxt, sp_r, sp_nxt, go;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, sp_cnt_r, sp_cnt_nxt;
    logic [NSECT-1:0] sel_r, sel_nxt;
    wire hit = cmd_ev && (wr_bank == BANK_W'(b)); // R26
    wire byp_eff = byp_r || acc_s; // R7
    wire cnt_zero = (cnt_r == '0);

    always_comb begin
      st_nxt = st_r;
      byp_nxt = byp_r;
      susp_nxt = susp_r;
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      sel_nxt = sel_r;
      sp_nxt = sp_r;
      sp_cnt_nxt = sp_cnt_r;
      go = 1'b0;
      case (st_r)
        ST_READ: begin
          if (hit && byp_eff && !susp_r) begin
            // only the bypass command set is decoded here
            if (wr_code == CMD_PROG) begin
              st_nxt = ST_PROG_ADDR; // R2 R5
            end else if (wr_code == CMD_SETUP) begin
              st_nxt = ST_BYP_80; // R5 R24
            end else if (wr_code == CMD_AUTOSEL) begin
              st_nxt = ST_BYP_RST; // R5 R6
            end
          end else if (hit && susp_r && wr_code == CMD_RESUME) begin
            st_nxt = ST_SE_BUSY; // R23
            susp_nxt = 1'b0;
          end else if (hit && is_cmd(wr_code, wr_low, CMD_UNLK1, ADDR_UNLK1)) begin
            st_nxt = ST_UNLK1;
          end
        end
        ST_UNLK1, ST_SETUP, ST_SU_UNLK1: begin
          if (hit) begin
            st_nxt = ST_READ;
            if (st_r == ST_SETUP && is_cmd(wr_code, wr_low, CMD_UNLK1, ADDR_UNLK1)) begin
              st_nxt = ST_SU_UNLK1;
            end else if (st_r != ST_SETUP && is_cmd(wr_code, wr_low, CMD_UNLK2, ADDR_UNLK2)) begin
              st_nxt = (st_r == ST_UNLK1) ? ST_UNLK2 : ST_SU_UNLK2;
            end
          end
        end
        ST_UNLK2: begin
          if (hit) begin
            st_nxt = ST_READ;
            if (!susp_r && is_cmd(wr_code, wr_low, CMD_BYPASS, ADDR_UNLK1)) begin
              byp_nxt = 1'b1; // R1
            end else if (is_cmd(wr_code, wr_low, CMD_PROG, ADDR_UNLK1)) begin
              st_nxt = ST_PROG_ADDR;
            end else if (!susp_r && is_cmd(wr_code, wr_low, CMD_SETUP, ADDR_UNLK1)) begin
              st_nxt = ST_SETUP; // R8 R12
            end else if (wr_code == CMD_AUTOSEL) begin
              st_nxt = ST_AUTOSEL; // R22
            end
          end
        end
        ST_SU_UNLK2, ST_BYP_80: begin
          if (hit) begin
            st_nxt = ST_READ;
            if (wr_code == CMD_CHIP && (st_r == ST_BYP_80 || wr_low == ADDR_UNLK1)) begin
              st_nxt = ST_CHIP_BUSY; // R3 R8
              sel_nxt = '1;
              pre_nxt = 1'b1;
              cnt_nxt = CNT_W'(PREPROG_CYCLES);
            end else if (wr_code == CMD_SECTOR) begin
              st_nxt = ST_SE_WINDOW; // R4 R12 R24
              sel_nxt[wr_sect] = 1'b1;
              cnt_nxt = CNT_W'(SE_WINDOW_CYCLES);
            end
          end
        end
        ST_BYP_RST: begin
          if (hit) begin
            st_nxt = ST_READ;
            if (wr_code == CMD_BYP_EXIT) begin
              byp_nxt = 1'b0; // R6
            end
          end
        end
        ST_PROG_ADDR: begin
          if (hit) begin
            go = 1'b1; // R2
            st_nxt = ST_PROG_BUSY;
            sp_cnt_nxt = CNT_W'(PROG_CYCLES);
          end
        end
        ST_PROG_BUSY: begin
          // own counter, so a suspended erase keeps its remaining count
          if (sp_cnt_r == '0) begin
            st_nxt = ST_READ; // R22
          end else begin
            sp_cnt_nxt = sp_cnt_r - 1'b1;
          end
        end
        ST_SE_WINDOW: begin
          if (hit && wr_code == CMD_SECTOR) begin
            sel_nxt[wr_sect] = 1'b1; // R13
            cnt_nxt = CNT_W'(SE_WINDOW_CYCLES); // R14
          end else if (hit && wr_code == CMD_SUSPEND) begin
            st_nxt = ST_READ; // R20
            susp_nxt = 1'b1;
            pre_nxt = 1'b1;
            cnt_nxt = CNT_W'(PREPROG_CYCLES);
          end else if (hit) begin
            st_nxt = ST_READ; // R15
            sel_nxt = '0;
          end else if (cnt_zero) begin
            st_nxt = ST_SE_BUSY; // R16
            pre_nxt = 1'b1;
            cnt_nxt = CNT_W'(PREPROG_CYCLES);
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        ST_CHIP_BUSY, ST_SE_BUSY: begin
          // chip erase ignores every write, sector erase only hears suspend
          if (hit && st_r == ST_SE_BUSY && wr_code == CMD_SUSPEND && !sp_r) begin
            sp_nxt = 1'b1; // R18 R19
            sp_cnt_nxt = CNT_W'(SUSP_LAT_CYCLES);
          end
          if (cnt_zero && pre_r) begin
            pre_nxt = 1'b0; // R9
            cnt_nxt = CNT_W'(ERASE_CYCLES);
          end else if (cnt_zero) begin
            st_nxt = ST_READ; // R10
            sel_nxt = '0;
            sp_nxt = 1'b0;
          end else if (sp_r && sp_cnt_r == '0) begin
            st_nxt = ST_READ; // R20
            susp_nxt = 1'b1;
            sp_nxt = 1'b0;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
            if (sp_r) begin
              sp_cnt_nxt = sp_cnt_r - 1'b1;
            end
          end
        end
        ST_AUTOSEL: begin
          if (hit && wr_code == CMD_RESET) begin
            st_nxt = ST_READ;
          end
        end
        default: begin
          st_nxt = ST_READ;
        end
      endcase
    end

    // hardware reset drops any erase in flight
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        st_r <= ST_READ; // R11
        {byp_r, susp_r, pre_r, sp_r} <= '0;
        {cnt_r, sp_cnt_r, sel_r} <= '0;
      end else begin
        st_r <= st_nxt;
        byp_r <= byp_nxt;
        susp_r <= susp_nxt;
        pre_r <= pre_nxt;
        sp_r <= sp_nxt;
        cnt_r <= cnt_nxt;
        sp_cnt_r <= sp_cnt_nxt;
        sel_r <= sel_nxt;
      end
    end

    assign prog_go[b] = go;
    assign st_w[b] = st_r;
    assign sel_w[b] = sel_r;
    assign susp_w[b] = susp_r;
    assign byp_w[b] = byp_eff;
    assign erase_w[b] = (st_r == ST_CHIP_BUSY) || (st_r == ST_SE_BUSY);
    assign busy_w[b] = erase_w[b] || (st_r == ST_PROG_BUSY) || (st_r == ST_SE_WINDOW);
    assign status_reg[b*STAT_STRIDE +: STAT_STRIDE] = {1'b0, erase_w[b] || susp_r, susp_r, byp_eff, st_r};
  end

  // read path: status for every address of a busy bank, or for the selected sectors of a suspended bank
  wire [BANK_W-1:0] rd_bank = addr_s[BANK_LO +: BANK_W];
  wire [SECT_W-1:0] rd_sect = addr_s[SECT_LO +: SECT_W];
  wire r_busy = busy_w[rd_bank];
  wire r_prog = (st_w[rd_bank] == ST_PROG_BUSY);
  wire r_sel = sel_w[rd_bank][rd_sect];
  wire r_susp = susp_w[rd_bank] && !r_busy;
  wire r_erase = erase_w[rd_bank] || susp_w[rd_bank];
  wire show_stat = r_busy || (r_susp && r_sel); // R17 R21
  logic [DATA_W-1:0] stat_word;

  always_comb begin
    stat_word = '0;
    stat_word[POLL_BIT] = r_prog ? !array_wr_data[POLL_BIT] : r_susp; // R10
    stat_word[TOGGLE_BIT] = r_busy && tog_r; // R10
    stat_word[WINDOW_BIT] = r_erase; // R16
    stat_word[ETOGGLE_BIT] = r_erase && r_sel && tog_r; // R21
  end

  wire [DATA_W-1:0] rd_word = show_stat ? stat_word : array_rdata;

  // program data keeps the full word, unlike command writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {flash_data_out, flash_data_oe, array_raddr, bank_busy} <= '0;
      {array_wr_en, array_wr_addr, array_wr_data} <= '0;
    end else begin
      flash_data_out <= rd_word;
      flash_data_oe <= !oe_s;
      array_raddr <= addr_s;
      bank_busy <= busy_w;
      array_wr_en <= |prog_go;
      if (|prog_go) begin
        array_wr_addr <= addr_s;
        array_wr_data <= data_s;
      end
    end
  end

  // register slave; address and data may arrive in either order
  logic aw_hold_r, w_hold_r;
  logic [AXI_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire r_done = s_axi_rvalid && s_axi_rready;
  wire wr_do = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire wr_map = (aw_addr_r == REG_CTRL) || (aw_addr_r == REG_STATUS);
  wire rd_map = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS);
  wire [31:0] ctrl_word = CTRL_RST | {31'b0, ctrl_lock_r};
  wire [31:0] rd_reg = (s_axi_araddr == REG_STATUS) ? status_reg :
                       (s_axi_araddr == REG_CTRL) ? ctrl_word : '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {aw_hold_r, w_hold_r, s_axi_bvalid, s_axi_rvalid} <= '0;
      {s_axi_awready, s_axi_wready, s_axi_arready} <= '1;
      {aw_addr_r, w_data_r, w_strb_r, s_axi_rdata} <= '0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rresp <= RESP_OKAY;
      ctrl_lock_r <= CTRL_RST[CTRL_LOCK_BIT];
    end else begin
      // ready drops on a take and returns only once the answer is accepted
      s_axi_awready <= !aw_take && (s_axi_awready || b_done);
      s_axi_wready <= !w_take && (s_axi_wready || b_done);
      s_axi_arready <= !ar_take && (s_axi_arready || r_done);
      aw_hold_r <= aw_take || (aw_hold_r && !wr_do);
      w_hold_r <= w_take || (w_hold_r && !wr_do);
      s_axi_bvalid <= wr_do || (s_axi_bvalid && !s_axi_bready);
      s_axi_rvalid <= ar_take || (s_axi_rvalid && !s_axi_rready);
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr_r == REG_CTRL && w_strb_r[0]) begin
          ctrl_lock_r <= w_data_r[CTRL_LOCK_BIT];
        end
      end
      if (ar_take) begin
        s_axi_rdata <= rd_reg;
        s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule

// ### test/fbess_host.sv
`timescale 1ns/1ns
module fbess_host
  import fbess_pkg::*;
(
  input wire logic clk,
  output logic flash_we_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_data
);
  int seed = 32'h0863_6bd5;
  int slow = 0;
  initial begin
    flash_we_n = 1'b1;
    flash_addr = '0;
    flash_data = '0;
  end
  function automatic logic [DATA_W-1:0] rnd16();
    return DATA_W'($random(seed));
  endfunction
  function automatic logic [ADDR_W-1:0] fa(input logic [1:0] b, input logic [5:0] s, input logic [11:0] u);
    return {b, s, 1'b0, u};
  endfunction
  // strobe phases outlast the three-stage synchroniser; a released bus shows the inverse
  task automatic cyc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    flash_addr <= a;
    flash_data <= d;
    flash_we_n <= 1'b0;
    repeat (5) @(posedge clk);
    flash_we_n <= 1'b1;
    repeat (6) @(posedge clk);
    flash_addr <= ~a;
    flash_data <= ~d;
    repeat (2 + slow) @(posedge clk);
  endtask
  task automatic park(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    flash_addr <= a;
  endtask
  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [7:0] k);
    logic [DATA_W-1:0] r;
    r = rnd16();
    cyc(a, {r[15:8], k});
  endtask
  task automatic unlock(input logic [1:0] b);
    cmd(fa(b, 6'h00, ADDR_UNLK1), CMD_UNLK1);
    cmd(fa(b, 6'h00, ADDR_UNLK2), CMD_UNLK2);
  endtask
  task automatic seq3(input logic [1:0] b, input logic [7:0] k);
    unlock(b);
    cmd(fa(b, 6'h00, ADDR_UNLK1), k);
  endtask
  task automatic erase6(input logic [1:0] b, input logic [5:0] s, input logic [7:0] k);
    seq3(b, CMD_SETUP);
    unlock(b);
    cmd(fa(b, s, ADDR_UNLK1), k);
  endtask
endmodule

// ### test/fbess_monitor.sv
`timescale 1ns/1ns
module fbess_chk
  import fbess_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic array_wr_en,
  input wire logic [ADDR_W-1:0] array_wr_addr,
  input wire logic [DATA_W-1:0] array_wr_data,
  input wire logic [NBANK-1:0] bank_busy
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |=> (!s_axi_awready && !s_axi_wready) ##[0:1] s_axi_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h08
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  prog_pulse_a: assert property (array_wr_en |=> !array_wr_en)
    else $error("array write longer than one cycle");
  prog_hold_a: assert property (!array_wr_en ##1 !array_wr_en |-> $stable(array_wr_addr) && $stable(array_wr_data))
    else $error("array write word changed without a write");
  busy_prog_a: assert property (array_wr_en |-> ##[0:2] (bank_busy != 4'b0000))
    else $error("no bank busy during program");
endmodule

// ### test/fbess_top_bench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin \
  comparisons++; \
  if ((gt) !== (ex)) begin \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); \
    mismatches++; \
  end \
end
module fbess_top_bench
  import fbess_pkg::*;
;
  localparam int WIN = 60;
  logic clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic flash_oe_n, accel_program_input, flash_we_n, flash_data_oe, array_wr_en;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bexp;
  logic [ADDR_W-1:0] flash_addr, array_raddr, array_wr_addr;
  logic [DATA_W-1:0] flash_data_in, flash_data_out, array_rdata, array_wr_data;
  logic [NBANK-1:0] bank_busy;
  logic [65:0] rexp;
  logic [36:0] wexp;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [36:0] wq[$];
  int mismatches = 0;
  int comparisons = 0;
  assign s_axi_wstrb = 4'hF;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) array_rdata <= DATA_W'($random(fbess_host_inst.seed));
  fbess_top #(.SE_WINDOW_CYCLES(WIN), .SUSP_LAT_CYCLES(10), .PROG_CYCLES(8), .PREPROG_CYCLES(10),
    .ERASE_CYCLES(60)) fbess_top_inst (.*);
  fbess_host fbess_host_inst (.clk, .flash_we_n, .flash_addr, .flash_data(flash_data_in));
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rexp = rq.pop_front();
      `CHK("read data", rexp[31:0], s_axi_rdata & rexp[63:32])
      `CHK("read resp", rexp[65:64], s_axi_rresp)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bexp = bq.pop_front();
      `CHK("write resp", bexp, s_axi_bresp)
    end
    if (array_wr_en) begin
      wexp = wq.pop_front();
      `CHK("program addr", wexp[36:16], array_wr_addr)
      `CHK("program data", wexp[15:0], array_wr_data)
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // k: 0 arready, 1 rvalid, 2 bvalid, 3.. bank k-3 idle
  task automatic wt(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(k == 0 ? s_axi_arready : k == 1 ? s_axi_rvalid : k == 2 ? s_axi_bvalid : !bank_busy[k-3])
      && n < 2000);
    if (n >= 2000) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] rs);
    rq.push_back({rs, m, e & m});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wt(0);
    s_axi_arvalid <= 1'b0;
    wt(1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    bit ad;
    bit wd;
    bq.push_back(rs);
    ad = 0;
    wd = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (50) if (!(ad && wd)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    wt(2);
    s_axi_bready <= 1'b0;
  endtask
  task automatic st(input int b, input logic [7:0] m, input logic [7:0] v);
    rd(REG_STATUS, 32'(m) << (8 * b), 32'(v) << (8 * b), RESP_OKAY);
  endtask
  task automatic c(input logic [1:0] b, input logic [5:0] s, input logic [7:0] k);
    fbess_host_inst.cmd(fbess_host_inst.fa(b, s, 12'h000), k);
  endtask
  task automatic fl(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
    fbess_host_inst.park(a);
    flash_oe_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("flash read", e & m, flash_data_out & m)
    `CHK("read enable", 1'b1, flash_data_oe)
    flash_oe_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic prog(input logic [1:0] b, input logic [5:0] s, input bit std);
    logic [DATA_W-1:0] d;
    logic [ADDR_W-1:0] a;
    d = fbess_host_inst.rnd16();
    a = fbess_host_inst.fa(b, s, d[11:0]);
    if (std) fbess_host_inst.seq3(b, CMD_PROG);
    else c(b, s, CMD_PROG);
    wq.push_back({a, d});
    fbess_host_inst.cyc(a, d);
    wt(3 + b);
  endtask
  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, accel_program_input} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    flash_oe_n = 1'b1;
    nrst = 1'b0;
    do_reset();
    rd(REG_STATUS, '1, 32'h0000_0000, RESP_OKAY);
    rd(REG_CTRL, '1, CTRL_RST, RESP_OKAY);
    rd(8'h08, '1, 32'h0000_0000, RESP_SLVERR);
    wr(8'h08, 32'h0000_0001, RESP_SLVERR);
    wr(REG_STATUS, '1, RESP_OKAY);
    rd(REG_STATUS, '1, 32'h0000_0000, RESP_OKAY);
    wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    rd(REG_CTRL, '1, 32'h0000_0001, RESP_OKAY);
    fbess_host_inst.unlock(2'd1);
    st(1, 8'h0F, 8'h00);
    wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    fin("registers");
    fbess_host_inst.seq3(2'd0, CMD_BYPASS);
    st(0, 8'h7F, 8'h10);
    c(0, 0, CMD_RESET);
    st(0, 8'h7F, 8'h10);
    prog(0, 3, 0);
    st(0, 8'h7F, 8'h10);
    c(0, 0, CMD_SETUP);
    c(0, 5, CMD_SECTOR);
    st(0, 8'h7F, 8'h1B);
    repeat (WIN + 8) @(posedge clk);
    st(0, 8'h7F, 8'h5C);
    wt(3);
    st(0, 8'h7F, 8'h10);
    c(0, 0, CMD_SETUP);
    c(0, 0, CMD_CHIP);
    st(0, 8'h0F, 8'h0A);
    wt(3);
    c(0, 0, CMD_AUTOSEL);
    c(0, 0, CMD_BYP_EXIT);
    st(0, 8'h7F, 8'h00);
    fin("bypass");
    fbess_host_inst.erase6(2'd1, 6'd0, CMD_CHIP);
    st(1, 8'h0F, 8'h0A);
    c(1, 0, CMD_SUSPEND);
    st(1, 8'h2F, 8'h0A);
    wt(4);
    st(1, 8'h7F, 8'h00);
    fin("chip erase");
    fbess_host_inst.erase6(2'd2, 6'd1, CMD_SECTOR);
    st(2, 8'h7F, 8'h0B);
    c(2, 4, CMD_SECTOR);
    fbess_host_inst.slow = 20;
    c(2, 9, CMD_SECTOR);
    fbess_host_inst.slow = 0;
    st(2, 8'h7F, 8'h0B);
    c(2, 0, CMD_SUSPEND);
    st(2, 8'h60, 8'h60);
    fl(fbess_host_inst.fa(2, 1, 12'h000), 16'h00BB, 16'h0088);
    prog(2, 20, 1);
    st(2, 8'h60, 8'h60);
    c(2, 0, CMD_RESUME);
    st(2, 8'h60, 8'h40);
    c(2, 0, CMD_RESUME);
    st(2, 8'h60, 8'h40);
    c(2, 0, CMD_SUSPEND);
    repeat (12) @(posedge clk);
    st(2, 8'h60, 8'h60);
    c(2, 0, CMD_RESUME);
    wt(5);
    st(2, 8'h7F, 8'h00);
    fin("suspend");
    fbess_host_inst.erase6(2'd3, 6'd2, CMD_SECTOR);
    c(3, 0, CMD_RESET);
    st(3, 8'h7F, 8'h00);
    fbess_host_inst.erase6(2'd3, 6'd2, CMD_SECTOR);
    repeat (WIN + 8) @(posedge clk);
    st(3, 8'h40, 8'h40);
    do_reset();
    rd(REG_STATUS, '1, 32'h0000_0000, RESP_OKAY);
    accel_program_input <= 1'b1;
    repeat (6) @(posedge clk);
    st(3, 8'h10, 8'h10);
    prog(3, 7, 0);
    accel_program_input <= 1'b0;
    repeat (6) @(posedge clk);
    st(3, 8'h10, 8'h00);
    fin("abort and accel");
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule
bind fbess_top fbess_chk fbess_chk_inst (.clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .array_wr_en, .array_wr_addr, .array_wr_data,
  .bank_busy);
